/* File: common/fbpse_bus_if.sv */
// Single flash bus cycle request and answer between sequencer and pin engine.
`timescale 1ns/10ps
interface fbpse_bus_if;
    import fbpse_pkg::*;
    logic req;
    logic wr;
    logic [FB_AW-1:0] addr;
    logic [FB_DW-1:0] wdata;
    logic ack;
    logic [FB_DW-1:0] rdata;
    modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
    modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

/* File: common/fbpse_pkg.sv */
// Constants, codes and types for the buffered-program and sector-erase flash controller.
// Summary of operation
// - Every sequence opens with 00aa at 555 then 0055 at 2aa.
// - Third program write is load code 0025 at the sector address.
// - Fourth write gives word count minus one, then 1 to 32 loads follow.
// - After the last load, confirm 0029 at the sector address starts programming.
// - Host should fill the buffer as full as possible for throughput.
// - All loads of one operation lie in one 32-word aligned page.
// - Sector erase: unlock, 0080 at 555, unlock, 0030 at sector.
// - Extra sectors in any order; gaps stay below the window.
// - Hardware reset ends an erase; host then reissues the sequence.
// - Host polls program status at the last loaded address.
package fbpse_pkg;
    localparam int FB_AW = 24;
    localparam int FB_DW = 16;
    localparam logic [FB_AW-1:0] ADDR_UNLOCK1 = 24'h000555;
    localparam logic [FB_AW-1:0] ADDR_UNLOCK2 = 24'h0002aa;
    localparam logic [FB_DW-1:0] CMD_UNLOCK1 = 16'h00aa;
    localparam logic [FB_DW-1:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [FB_DW-1:0] CMD_BUF_LOAD = 16'h0025;
    localparam logic [FB_DW-1:0] CMD_BUF_CONFIRM = 16'h0029;
    localparam logic [FB_DW-1:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [FB_DW-1:0] CMD_SECT_ERASE = 16'h0030;
    localparam logic [FB_DW-1:0] CMD_ABORT_RESET = 16'h00f0;
    localparam int PAGE_LSB = 5;
    localparam int SECT_LSB = 15;
    localparam int DATA_POLLING_BIT = 7;
    localparam int ERASE_TIMER_EXPIRED_BIT = 3;
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_WP_NS = 40;
    localparam int T_WPH_NS = 20;
    localparam int T_ACC_NS = 70;
    localparam int ERASE_ACCEPT_WINDOW_NS = 50000;
    localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SYNC_CYC = 8'h02;
    localparam logic [15:0] ERASE_WIN_CYC = 16'(ERASE_ACCEPT_WINDOW_NS / CLK_PERIOD_NS);
    typedef enum logic [1:0] {FBPSE_OP_PROG, FBPSE_OP_ERASE, FBPSE_OP_ABORT} fbpse_op_t;
endpackage

/* File: rtl/fbpse_ctrl.sv */
// Host sequencer issuing buffered program, sector erase and abort reset sequences.
`timescale 1ns/10ps
module fbpse_ctrl
    import fbpse_pkg::*;
#(
    parameter logic [15:0] GAP_LIMIT = ERASE_WIN_CYC - 16'(WPH_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire fbpse_op_t cmd_op,
    input wire logic [FB_AW-1:0] cmd_addr,
    input wire logic [4:0] cmd_count,
    output logic cmd_ready,
    input wire logic wr_valid,
    input wire logic [FB_AW-1:0] wr_addr,
    input wire logic [FB_DW-1:0] wr_data,
    output logic wr_ready,
    output logic busy,
    output logic done,
    output logic err,
    output logic erase_timer_expired_bit,
    output logic [FB_AW-1:0] fl_addr,
    input wire logic [FB_DW-1:0] fl_dq_i,
    output logic [FB_DW-1:0] fl_dq_o,
    output logic fl_dq_oe,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic fl_rst_n
);
    typedef enum logic [3:0] {S_IDLE, S_U1, S_U2, S_CMD3, S_U4, S_U5, S_COUNT, S_LWAIT, S_LOAD, S_CONF,
        S_SECT, S_GAP, S_POLL3, S_POLL7, S_F0} fbpse_state_t;
    fbpse_state_t st_reg, st_next;
    fbpse_op_t op_reg, op_next;
    logic [FB_AW-1:0] sect_reg, sect_next, lat_reg, lat_next, poll_reg, poll_next;
    logic [FB_AW-PAGE_LSB-1:0] page_reg, page_next;
    logic [FB_DW-1:0] data_reg, data_next;
    logic [4:0] cnt_reg, cnt_next, left_reg, left_next;
    logic [15:0] tmr_reg, tmr_next;
    logic first_reg, first_next, exp_reg, exp_next, err_reg, err_next, done_reg, done_next;
    logic exp3_reg, exp3_next, rst_pin_reg;
    logic cmd_take, wr_take;
    fbpse_bus_if bus ();

    fbpse_cycle u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .bus(bus),
        .fl_addr(fl_addr),
        .fl_dq_i(fl_dq_i),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n)
    );

    // ****************************************
    // Bus cycle per state
    // ****************************************
    always_comb begin
        bus.req = 1'b1;
        bus.wr = 1'b1;
        bus.addr = ADDR_UNLOCK1;
        bus.wdata = CMD_UNLOCK1;
        unique case (st_reg)
            S_U1, S_U4: begin
            end
            S_U2, S_U5: begin
                bus.addr = ADDR_UNLOCK2;
                bus.wdata = CMD_UNLOCK2;
            end
            S_CMD3: begin
                bus.addr = (op_reg == FBPSE_OP_PROG) ? sect_reg : ADDR_UNLOCK1;
                bus.wdata = (op_reg == FBPSE_OP_PROG) ? CMD_BUF_LOAD : CMD_ERASE_SETUP;
            end
            S_COUNT: begin
                bus.addr = sect_reg;
                bus.wdata = {11'h000, cnt_reg};
            end
            S_LOAD: begin
                bus.addr = lat_reg;
                bus.wdata = data_reg;
            end
            S_CONF: begin
                bus.addr = sect_reg;
                bus.wdata = CMD_BUF_CONFIRM;
            end
            S_SECT: begin
                bus.addr = lat_reg;
                bus.wdata = CMD_SECT_ERASE;
            end
            S_F0: begin
                bus.wdata = CMD_ABORT_RESET;
            end
            S_POLL3, S_POLL7: begin
                bus.wr = 1'b0;
                bus.addr = poll_reg;
            end
            S_IDLE, S_LWAIT, S_GAP: begin
                bus.req = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    assign cmd_take = cmd_valid && cmd_ready;
    assign wr_take = wr_valid && wr_ready;

    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        sect_next = sect_reg;
        lat_next = lat_reg;
        poll_next = poll_reg;
        page_next = page_reg;
        data_next = data_reg;
        cnt_next = cnt_reg;
        left_next = left_reg;
        tmr_next = tmr_reg;
        first_next = first_reg;
        exp_next = exp_reg;
        err_next = err_reg;
        exp3_next = exp3_reg;
        done_next = 1'b0;
        unique case (st_reg)
            S_IDLE: begin
                if (cmd_take) begin
                    op_next = cmd_op;
                    sect_next = cmd_addr;
                    lat_next = cmd_addr;
                    poll_next = cmd_addr;
                    cnt_next = cmd_count;
                    left_next = cmd_count;
                    first_next = 1'b1;
                    err_next = 1'b0;
                    exp3_next = 1'b0;
                    exp_next = 1'b1;
                    st_next = S_U1;
                end
            end
            S_U1: if (bus.ack) st_next = S_U2;
            S_U2: begin
                if (bus.ack) begin
                    st_next = (op_reg == FBPSE_OP_ABORT) ? S_F0 : S_CMD3;
                end
            end
            S_CMD3: if (bus.ack) st_next = (op_reg == FBPSE_OP_PROG) ? S_COUNT : S_U4;
            S_U4: if (bus.ack) st_next = S_U5;
            S_U5: if (bus.ack) st_next = S_SECT;
            S_COUNT: if (bus.ack) st_next = S_LWAIT;
            S_LWAIT: begin
                if (wr_take) begin
                    // page bits top down to five
                    if ((!first_reg && wr_addr[FB_AW-1:PAGE_LSB] != page_reg) ||
                        wr_addr[FB_AW-1:SECT_LSB] != sect_reg[FB_AW-1:SECT_LSB]) begin
                        // A foreign load is never sent; the device is parked in abort and reset instead.
                        err_next = 1'b1;
                        op_next = FBPSE_OP_ABORT;
                        st_next = S_U1;
                    end else begin
                        if (first_reg) page_next = wr_addr[FB_AW-1:PAGE_LSB];
                        first_next = 1'b0;
                        lat_next = wr_addr;
                        data_next = wr_data;
                        st_next = S_LOAD;
                    end
                end
            end
            S_LOAD: begin
                if (bus.ack) begin
                    poll_next = lat_reg;
                    exp_next = data_reg[DATA_POLLING_BIT];
                    if (left_reg == 5'h00) begin
                        st_next = S_CONF;
                    end else begin
                        left_next = left_reg - 5'h01;
                        st_next = S_LWAIT;
                    end
                end
            end
            S_CONF: if (bus.ack) st_next = S_POLL7;
            S_SECT: begin
                if (bus.ack) begin
                    tmr_next = 16'h0000;
                    st_next = S_GAP;
                end
            end
            S_GAP: begin
                tmr_next = tmr_reg + 16'h0001;
                if (left_reg == 5'h00) begin
                    st_next = S_POLL3;
                end else if (wr_take) begin
                    lat_next = wr_addr;
                    left_next = left_reg - 5'h01;
                    st_next = S_SECT;
                end else if (tmr_reg >= GAP_LIMIT) begin
                    err_next = 1'b1;
                    st_next = S_POLL3;
                end
            end
            S_POLL3: begin
                if (bus.ack && bus.rdata[ERASE_TIMER_EXPIRED_BIT]) begin
                    exp3_next = 1'b1;
                    st_next = S_POLL7;
                end
            end
            S_POLL7: begin
                if (bus.ack && bus.rdata[DATA_POLLING_BIT] == exp_reg) begin
                    done_next = 1'b1;
                    st_next = S_IDLE;
                end
            end
            S_F0: begin
                if (bus.ack) begin
                    done_next = 1'b1;
                    st_next = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= S_IDLE;
            op_reg <= FBPSE_OP_PROG;
            sect_reg <= '0;
            lat_reg <= '0;
            poll_reg <= '0;
            page_reg <= '0;
            data_reg <= '0;
            cnt_reg <= 5'h00;
            left_reg <= 5'h00;
            tmr_reg <= 16'h0000;
            first_reg <= 1'b1;
            exp_reg <= 1'b1;
            err_reg <= 1'b0;
            done_reg <= 1'b0;
            exp3_reg <= 1'b0;
            cmd_ready <= 1'b0;
            wr_ready <= 1'b0;
            busy <= 1'b0;
            rst_pin_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            sect_reg <= sect_next;
            lat_reg <= lat_next;
            poll_reg <= poll_next;
            page_reg <= page_next;
            data_reg <= data_next;
            cnt_reg <= cnt_next;
            left_reg <= left_next;
            tmr_reg <= tmr_next;
            first_reg <= first_next;
            exp_reg <= exp_next;
            err_reg <= err_next;
            done_reg <= done_next;
            exp3_reg <= exp3_next;
            cmd_ready <= (st_next == S_IDLE);
            wr_ready <= (st_next == S_LWAIT) || (st_next == S_GAP && left_next != 5'h00);
            busy <= (st_next != S_IDLE);
            rst_pin_reg <= 1'b1;
        end
    end

    assign done = done_reg;
    assign err = err_reg;
    assign erase_timer_expired_bit = exp3_reg;
    assign fl_rst_n = rst_pin_reg;

    // ****************************************
    // Checks
    // ****************************************
    sequence unlock_pair;
        st_reg == S_U1 && bus.ack ##1 st_reg == S_U2 && bus.addr == ADDR_UNLOCK2 && bus.wdata == CMD_UNLOCK2;
    endsequence
    sequence open_first;
        cmd_take ##1 st_reg == S_U1 && bus.req && bus.addr == ADDR_UNLOCK1 && bus.wdata == CMD_UNLOCK1;
    endsequence
    property p_open;
        @(posedge clk) disable iff (!rst_n) cmd_take |-> open_first;
    endproperty
    a_unlock_first: assert property (p_open) else $error("sequence does not open with unlock");
    a_unlock_second: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_U1 && bus.ack |-> unlock_pair) else $error("second unlock missing");
    a_load_code: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st_reg == S_CMD3) && op_reg == FBPSE_OP_PROG |-> bus.wdata == CMD_BUF_LOAD && bus.addr == sect_reg)
        else $error("load code wrong");
    a_count_word: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_CMD3 && op_reg == FBPSE_OP_PROG && bus.ack |=> st_reg == S_COUNT && bus.wdata[4:0] == left_reg)
        else $error("count word wrong");
    a_confirm_after: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_LOAD && bus.ack && left_reg == 5'h00 |=> st_reg == S_CONF && bus.wdata == CMD_BUF_CONFIRM)
        else $error("confirm not issued after last load");
    a_same_page: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_LOAD |-> bus.addr[FB_AW-1:PAGE_LSB] == page_reg) else $error("load leaves page");
    a_load_counts: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_LOAD && bus.ack && left_reg != 5'h00 |=> left_reg == $past(left_reg) - 5'h01)
        else $error("load counter not decremented");
    a_abort_code: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_U2 && bus.ack && op_reg == FBPSE_OP_ABORT |=> bus.addr == ADDR_UNLOCK1 && bus.wdata == CMD_ABORT_RESET)
        else $error("abort reset code wrong");
    a_erase_code: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_U5 && bus.ack |=> bus.wdata == CMD_SECT_ERASE ##1 st_reg == S_SECT)
        else $error("erase command wrong");
    a_gap_bound: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_GAP |-> tmr_reg <= GAP_LIMIT) else $error("erase gap too long");
    a_poll_last: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg == S_POLL7 && op_reg == FBPSE_OP_PROG |-> bus.addr == lat_reg) else $error("poll address wrong");
endmodule

/* File: rtl/fbpse_cycle.sv */
// Pin engine that runs one timed flash write or read cycle per request.
`timescale 1ns/10ps
module fbpse_cycle
    import fbpse_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    fbpse_bus_if.engine bus,
    output logic [FB_AW-1:0] fl_addr,
    input wire logic [FB_DW-1:0] fl_dq_i,
    output logic [FB_DW-1:0] fl_dq_o,
    output logic fl_dq_oe,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n
);
    typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_READ} fbpse_cst_t;
    fbpse_cst_t st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [FB_AW-1:0] addr_reg, addr_next;
    logic [FB_DW-1:0] dq_reg, dq_next, rdata_reg, rdata_next, sync1_reg, sync2_reg;
    logic oe_reg, oe_next, ce_reg, ce_next, rd_reg, rd_next, we_reg, we_next, ack_reg, ack_next;

    // ****************************************
    // Cycle sequencing
    // ****************************************
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        dq_next = dq_reg;
        rdata_next = rdata_reg;
        oe_next = oe_reg;
        ce_next = ce_reg;
        rd_next = rd_reg;
        we_next = we_reg;
        ack_next = 1'b0;
        unique case (st_reg)
            C_IDLE: begin
                // The answer cycle is skipped so the master can present its next request.
                if (bus.req && !ack_reg) begin
                    addr_next = bus.addr;
                    dq_next = bus.wdata;
                    ce_next = 1'b0;
                    if (bus.wr) begin
                        oe_next = 1'b1;
                        st_next = C_SETUP;
                    end else begin
                        rd_next = 1'b0;
                        cnt_next = ACC_CYC + SYNC_CYC;
                        st_next = C_READ;
                    end
                end
            end
            C_SETUP: begin
                we_next = 1'b0;
                cnt_next = WP_CYC - 8'h01;
                st_next = C_STROBE;
            end
            C_STROBE: begin
                if (cnt_reg == 8'h00) begin
                    we_next = 1'b1;
                    cnt_next = WPH_CYC - 8'h01;
                    st_next = C_HOLD;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            C_HOLD: begin
                if (cnt_reg == 8'h00) begin
                    ce_next = 1'b1;
                    oe_next = 1'b0;
                    ack_next = 1'b1;
                    st_next = C_IDLE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            C_READ: begin
                if (cnt_reg == 8'h00) begin
                    rdata_next = sync2_reg;
                    ce_next = 1'b1;
                    rd_next = 1'b1;
                    ack_next = 1'b1;
                    st_next = C_IDLE;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        sync1_reg <= fl_dq_i;
        sync2_reg <= sync1_reg;
        if (!rst_n) begin
            st_reg <= C_IDLE;
            cnt_reg <= 8'h00;
            addr_reg <= '0;
            dq_reg <= '0;
            rdata_reg <= '0;
            oe_reg <= 1'b0;
            ce_reg <= 1'b1;
            rd_reg <= 1'b1;
            we_reg <= 1'b1;
            ack_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            rdata_reg <= rdata_next;
            oe_reg <= oe_next;
            ce_reg <= ce_next;
            rd_reg <= rd_next;
            we_reg <= we_next;
            ack_reg <= ack_next;
        end
    end

    assign fl_addr = addr_reg;
    assign fl_dq_o = dq_reg;
    assign fl_dq_oe = oe_reg;
    assign fl_ce_n = ce_reg;
    assign fl_oe_n = rd_reg;
    assign fl_we_n = we_reg;
    assign bus.ack = ack_reg;
    assign bus.rdata = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(fl_we_n) |-> !fl_we_n [*2] ##1 fl_we_n) else $error("write strobe width wrong");
    a_no_contention: assert property (@(posedge clk) disable iff (!rst_n)
        !fl_oe_n |-> !fl_dq_oe && fl_we_n) else $error("read and drive overlap");
endmodule

/* File: tb/fbpse_ctrl_tb.sv */
// Self-checking bench for the buffered program and sector erase controller.
`timescale 1ns/10ps
module fbpse_ctrl_tb;
    import fbpse_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    fbpse_op_t cmd_op = FBPSE_OP_PROG;
    logic [FB_AW-1:0] cmd_addr = 24'h000000;
    logic [4:0] cmd_count = 5'h00;
    logic wr_valid = 1'b0;
    logic [FB_AW-1:0] wr_addr = 24'h000000;
    logic [FB_DW-1:0] wr_data = 16'h0000;
    logic cmd_ready, wr_ready, busy, done, err, tmr, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
    logic [FB_AW-1:0] fl_addr;
    logic [FB_DW-1:0] fl_dq_i, fl_dq_o;
    logic [FB_AW-1:0] xa[$];
    logic [FB_DW-1:0] xd[$];
    int n_fail = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    fbpse_ctrl #(.GAP_LIMIT(16'h0032)) i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_ready(wr_ready), .busy(busy), .done(done), .err(err), .erase_timer_expired_bit(tmr),
        .fl_addr(fl_addr), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n));
    fbpse_flash_model i_mdl (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_dq_i(fl_dq_i));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic ex(input logic [23:0] a, input logic [15:0] d);
        xa.push_back(a);
        xd.push_back(d);
    endtask
    task automatic unlock();
        ex(ADDR_UNLOCK1, CMD_UNLOCK1);
        ex(ADDR_UNLOCK2, CMD_UNLOCK2);
    endtask
    task automatic start(input fbpse_op_t op, input logic [23:0] a, input logic [4:0] n);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_count <= n;
        cmd_valid <= 1'b1;
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        chk("busy", 24'h1, {23'h0, busy});
        @(posedge clk);
    endtask
    // Valid stays high between words so it is never driven twice in one step.
    task automatic send(input logic [23:0] a, input logic [15:0] d);
        wr_addr <= a;
        wr_data <= d;
        wr_valid <= 1'b1;
        @(negedge clk);
        while (wr_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
    task automatic fin(input logic e);
        int k;
        wr_valid <= 1'b0;
        k = 0;
        @(negedge clk);
        while (done !== 1'b1 && k < 9000) begin
            k++;
            @(negedge clk);
        end
        chk("done", 24'h1, {23'h0, done});
        chk("busy", 24'h0, {23'h0, busy});
        chk("bus drive", 24'h0, {23'h0, fl_dq_oe});
        chk("flash reset", 24'h1, {23'h0, fl_rst_n});
        chk("error", {23'h0, e}, {23'h0, err});
        chk("writes", 24'(xa.size()), 24'(i_mdl.wa.size()));
        foreach (xa[i]) begin
            chk("addr", xa[i], i_mdl.wa[i]);
            chk("data", xd[i], i_mdl.wd[i]);
        end
        xa.delete();
        xd.delete();
        i_mdl.wa.delete();
        i_mdl.wd.delete();
        @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
    initial begin
        int n, k, bad;
        logic [23:0] s, p, a;
        logic [15:0] d;
        void'($urandom(32'h6c618b2f));
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk("flash reset", 24'h0, {23'h0, fl_rst_n});
        @(posedge clk);
        rst_n <= 1'b1;
        // Program: smallest, largest and random counts, the last with a foreign page.
        for (int t = 0; t < 6; t++) begin
            n = (t == 0) ? 0 : (t == 1 || t == 5) ? 31 : $urandom_range(30, 1);
            bad = (t == 5) ? 2 : 99;
            s = {9'($urandom), 15'h0000};
            p = s | {9'h000, 10'($urandom), 5'h00};
            unlock();
            ex(s, CMD_BUF_LOAD);
            ex(s, 16'(n));
            start(FBPSE_OP_PROG, s, 5'(n));
            for (k = 0; k <= n && k <= bad; k++) begin
                d = 16'($urandom) | 16'h8000;
                a = (k == bad) ? p + 24'h20 : p | 24'($urandom_range(31, 0));
                if (k < bad) ex(a, d);
                send(a, d);
            end
            if (k > bad) begin
                unlock();
                ex(ADDR_UNLOCK1, CMD_ABORT_RESET);
            end else begin
                ex(s, CMD_BUF_CONFIRM);
            end
            fin(k > bad);
        end
        // Erase: extra sectors in random order, the last run lets the window lapse.
        for (int t = 0; t < 4; t++) begin
            n = (t == 0) ? 0 : $urandom_range(4, 1);
            s = {9'($urandom), 15'h0000};
            unlock();
            ex(ADDR_UNLOCK1, CMD_ERASE_SETUP);
            unlock();
            ex(s, CMD_SECT_ERASE);
            start(FBPSE_OP_ERASE, s, 5'(n));
            for (k = 0; k < n - int'(t == 3); k++) begin
                a = {9'($urandom), 15'h0000};
                ex(a, CMD_SECT_ERASE);
                send(a, 16'($urandom));
            end
            fin(t == 3);
            chk("timer", 24'h1, {23'h0, tmr});
        end
        // Hardware reset in mid erase polling: the sequence is dropped and the flash reset pulses.
        unlock();
        ex(ADDR_UNLOCK1, CMD_ERASE_SETUP);
        unlock();
        ex(24'h008000, CMD_SECT_ERASE);
        start(FBPSE_OP_ERASE, 24'h008000, 5'h00);
        do @(negedge clk); while (fl_oe_n !== 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("flash reset", 24'h0, {23'h0, fl_rst_n});
        chk("busy", 24'h0, {23'h0, busy});
        @(posedge clk);
        unlock();
        ex(ADDR_UNLOCK1, CMD_ABORT_RESET);
        start(FBPSE_OP_ABORT, 24'h000000, 5'h00);
        fin(1'b0);
        finish_test();
    end
endmodule

/* File: tb/fbpse_flash_model.sv */
// Behavioural flash device that logs command writes and answers status polls.
`timescale 1ns/10ps
module fbpse_flash_model
    import fbpse_pkg::*;
(
    input wire logic [FB_AW-1:0] fl_addr,
    input wire logic [FB_DW-1:0] fl_dq_o,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic fl_rst_n,
    output logic [FB_DW-1:0] fl_dq_i
);
    logic [FB_AW-1:0] wa[$];
    logic [FB_DW-1:0] wd[$];
    logic [FB_DW-1:0] last_d = 16'h0000;
    logic [FB_DW-1:0] prog_d = 16'h0000;
    logic erase = 1'b0;
    logic tgl = 1'b0;
    int polls = 0;
    // busy count, stepped by reads and cut short by hardware reset.
    // One process owns the busy count; a read never overlaps a write, so the pin levels tell the events apart.
    always @(posedge fl_we_n or negedge fl_oe_n or negedge fl_rst_n) begin
        if (fl_rst_n !== 1'b1) begin
            polls = 0;
        end else if (fl_oe_n === 1'b0) begin
            if (polls > 0) begin
                polls = polls - 1;
                tgl = ~tgl;
            end
        end else if (fl_ce_n === 1'b0 && fl_we_n === 1'b1) begin
            wa.push_back(fl_addr);
            wd.push_back(fl_dq_o);
            if (fl_dq_o == CMD_BUF_CONFIRM) begin
                prog_d = last_d;
                polls = 3;
            end
            erase = (fl_dq_o == CMD_SECT_ERASE);
            if (erase) begin
                polls = 4;
            end
            last_d = fl_dq_o;
        end
    end
    // progress bits while busy.
    // A released bus shows the inverse of its last value so stale data never passes.
    always_comb begin
        if (fl_ce_n || fl_oe_n) begin
            fl_dq_i = ~last_d;
        end else if (polls > 0) begin
            fl_dq_i = {8'h00, ~erase & ~prog_d[7], tgl, 2'b00, erase && polls < 3, tgl, 2'b00};
        end else begin
            fl_dq_i = erase ? 16'hffff : prog_d;
        end
    end
endmodule
